// File: hdl/sspc_pkg.sv
// package for the standby and suspend power control block
package sspc_pkg;
    // register byte addresses
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STAT = 8'h04;
    localparam logic [7:0] ADDR_CLR = 8'h08;
    localparam logic [7:0] ADDR_WARN = 8'h0c;
    localparam logic [7:0] ADDR_BATT = 8'h10;
    localparam logic [7:0] ADDR_LB1 = 8'h14;
    localparam logic [7:0] ADDR_STATE = 8'h18;
    // control register fields
    localparam int CTRL_STBY_EN = 0;
    localparam int CTRL_SUSP_REQ = 1;
    localparam int CTRL_RESUME = 2;
    localparam int CTRL_SW_REQ = 3;
    localparam int CTRL_SMI_DONE = 4;
    localparam int CTRL_HALT_REQ = 5;
    // management status cause bits
    localparam int NCAUSE = 8;
    localparam int CS_ACT = 0;
    localparam int CS_HDD = 1;
    localparam int CS_IDLE = 2;
    localparam int CS_BTN = 3;
    localparam int CS_SWT = 4;
    localparam int CS_LB1 = 5;
    localparam int CS_LB2 = 6;
    localparam int CS_WAKE = 7;
    // axi response codes
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // timing: refresh during suspend, then reset values
    localparam int CLK_HZ = 125_000_000;
    localparam int REFRESH_HZ = 32_000;
    localparam int REFRESH_DIV = CLK_HZ / REFRESH_HZ;
    localparam logic [31:0] RESET_WORD = 32'h0000_0000;
    localparam logic [7:0] LB1_RESET = 8'h20;
    // power states, gray ordered along on->standby->suspend
    typedef enum logic [1:0] {
        ST_ON = 2'b00,
        ST_STBY = 2'b01,
        ST_SUSP = 2'b11,
        ST_WAKE = 2'b10
    } sspc_state_t;
    // suspended-domain control outputs
    typedef struct packed {
        logic clkgen_lowpwr;
        logic mcu_deep_sleep;
        logic refresh_slow;
        logic io_wake_keep;
    } sspc_susp_t;
endpackage

// File: hdl/sspc_top.sv
// standby and suspend power control with an AXI4-Lite register slave
// Contract
// - halt cpu clock when idle, release on interrupt
// - hard drive access ends local standby
// - suspend keeps refresh at 32 kHz
// - suspend: clock generator low, cpu halted
// - suspend puts housekeeping controller to sleep
// - all inactivity timers expired starts suspend; the code only raises the idle cause, suspend needs the request bit
// - suspend button raises management interrupt
// - private memory enabled only during service
// - battery byte received serially into register
// - battery at or below set point flags
// - loading warning timer starts countdown; sw bit
// - warning expiry raises interrupt, cause shown
// - modem ring or clock alarm wakes
// - wake detection stays powered in suspend
// - button in suspend releases clock halt
// - low battery two masks button push
// - standby activity raises management interrupt
`timescale 1ns/1ps
`default_nettype none
module sspc_top
    import sspc_pkg::*;
#(
    parameter int WARN_W = 32
) (
    input wire logic SYS_CLK,
    input wire logic RST,
    input wire logic [7:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [7:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    input wire logic PERIPH_ACT,
    input wire logic HDD_ACCESS,
    input wire logic TIMERS_EXPIRED,
    input wire logic SUSP_BUTTON,
    input wire logic MODEM_RING,
    input wire logic RTC_ALARM,
    input wire logic LOW_BATT2,
    input wire logic BATT_SCLK,
    input wire logic BATT_SDATA,
    output logic CPU_CLOCK_HALT,
    output logic SYSTEM_MGMT_INTERRUPT,
    output logic MGMT_PRIVATE_MEMORY_EN,
    output logic REFRESH_TICK,
    output logic CLKGEN_LOWPWR,
    output logic MCU_DEEP_SLEEP,
    output logic IO_WAKE_ACTIVE,
    output logic LOW_BATT1_FLAG
);
    // two-flop synchronisers for all pin inputs
    localparam int NPIN = 9;
    logic [NPIN-1:0] pin_raw;
    logic [NPIN-1:0] meta_r;
    logic [NPIN-1:0] sync_r;
    logic [NPIN-1:0] prev_r;
    logic [NPIN-1:0] rise;
    assign pin_raw = {BATT_SDATA, BATT_SCLK, LOW_BATT2, RTC_ALARM,
                      MODEM_RING, SUSP_BUTTON, TIMERS_EXPIRED,
                      HDD_ACCESS, PERIPH_ACT};
    // first stage only feeds the second
    always_ff @(posedge SYS_CLK) begin
        meta_r <= RST ? '0 : pin_raw;
        sync_r <= RST ? '0 : meta_r;
        prev_r <= RST ? '0 : sync_r;
    end
    assign rise = sync_r & ~prev_r;
    wire act_s = sync_r[0];
    wire hdd_e = rise[1];
    wire tmr_s = sync_r[2];
    wire btn_e = rise[3];
    wire wake_e = rise[4] | rise[5];
    wire lb2_s = sync_r[6];
    wire sclk_e = rise[7];
    wire sdat_s = sync_r[8];

    // register state
    logic [31:0] ctrl_r, ctrl_nxt;
    logic [NCAUSE-1:0] cause_r, cause_nxt;
    logic [WARN_W-1:0] warn_r, warn_nxt;
    logic [7:0] batt_r, batt_nxt;
    logic [7:0] lb1_r, lb1_nxt;
    logic [7:0] shift_r, shift_nxt;
    logic [2:0] bitcnt_r, bitcnt_nxt;
    sspc_state_t state_r, state_nxt;
    logic halt_r, halt_nxt;
    logic pmem_r, pmem_nxt;
    logic [15:0] refcnt_r, refcnt_nxt;
    logic tick_r, tick_nxt;
    sspc_susp_t susp_r, susp_nxt;
    logic lb1f_r, lb1f_nxt;
    logic smi_r, smi_nxt; // any cause pending, kept in a flop for the pin
    // bus channel state
    logic awrdy_r, awrdy_nxt, wrdy_r, wrdy_nxt; // readiness pins
    logic awr_r, awr_nxt, wr_r, wr_nxt, bv_r, bv_nxt;
    logic [7:0] awa_r, awa_nxt;
    logic [31:0] wd_r, wd_nxt;
    logic [3:0] ws_r, ws_nxt;
    logic [1:0] bresp_r, bresp_nxt;
    logic arr_r, arr_nxt, rv_r, rv_nxt;
    logic [31:0] rd_r, rd_nxt;
    logic [1:0] rresp_r, rresp_nxt;

    // address decode shared by read and write
    function automatic logic known(input logic [7:0] a);
        case (a)
            ADDR_CTRL, ADDR_STAT, ADDR_CLR, ADDR_WARN, ADDR_BATT,
            ADDR_LB1, ADDR_STATE: known = 1'b1;
            default: known = 1'b0;
        endcase
    endfunction

    // byte-lane merge for writes
    function automatic logic [31:0] merge(input logic [31:0] old,
            input logic [31:0] d, input logic [3:0] s);
        merge = old;
        for (int i = 0; i < 4; i++) begin
            if (s[i]) begin
                merge[i*8 +: 8] = d[i*8 +: 8];
            end
        end
    endfunction

    wire do_wr = awr_r & wr_r & ~bv_r;
    wire [31:0] ctrl_new = merge(ctrl_r, wd_r, ws_r);
    wire wr_ctrl = do_wr && awa_r == ADDR_CTRL;
    wire wr_clr = do_wr && awa_r == ADDR_CLR;
    wire wr_warn = do_wr && awa_r == ADDR_WARN;
    wire wr_lb1 = do_wr && awa_r == ADDR_LB1;

    // axi write and read channels
    always_comb begin
        awr_nxt = awr_r;
        awa_nxt = awa_r;
        wr_nxt = wr_r;
        wd_nxt = wd_r;
        ws_nxt = ws_r;
        bv_nxt = bv_r;
        bresp_nxt = bresp_r;
        arr_nxt = arr_r;
        rv_nxt = rv_r;
        rd_nxt = rd_r;
        rresp_nxt = rresp_r;
        // capture address and data in any order
        if (S_AXI_AWVALID && !awr_r) begin
            awr_nxt = 1'b1;
            awa_nxt = S_AXI_AWADDR;
        end
        if (S_AXI_WVALID && !wr_r) begin
            wr_nxt = 1'b1;
            wd_nxt = S_AXI_WDATA;
            ws_nxt = S_AXI_WSTRB;
        end
        if (do_wr) begin
            bv_nxt = 1'b1;
            bresp_nxt = known(awa_r) ? RESP_OKAY : RESP_SLVERR;
        end
        if (bv_r && S_AXI_BREADY) begin
            bv_nxt = 1'b0;
            awr_nxt = 1'b0;
            wr_nxt = 1'b0;
        end
        // reads answer in the same cycle that the address is taken, rvalid with arready
        if (S_AXI_ARVALID && !arr_r && !rv_r) begin
            arr_nxt = 1'b1;
            rv_nxt = 1'b1;
            rresp_nxt = known(S_AXI_ARADDR) ? RESP_OKAY : RESP_SLVERR;
            case (S_AXI_ARADDR)
                ADDR_CTRL: rd_nxt = ctrl_r;
                ADDR_STAT: rd_nxt = {24'h0, cause_r};
                ADDR_WARN: rd_nxt = 32'(warn_r);
                ADDR_BATT: rd_nxt = {24'h0, batt_r};
                ADDR_LB1: rd_nxt = {24'h0, lb1_r};
                ADDR_STATE: rd_nxt = {26'h0, lb1f_r, pmem_r, halt_r,
                                      lb2_s, state_r};
                default: rd_nxt = RESET_WORD;
            endcase
        end else begin
            arr_nxt = 1'b0;
        end
        if (rv_r && S_AXI_RREADY) begin
            rv_nxt = 1'b0;
        end
        // readiness is the inverse of the capture flags, from flops of its own
        awrdy_nxt = ~awr_nxt;
        wrdy_nxt = ~wr_nxt;
    end

    // serial battery byte, msb first on rising clock edge
    always_comb begin
        shift_nxt = shift_r;
        bitcnt_nxt = bitcnt_r;
        batt_nxt = batt_r;
        if (sclk_e) begin
            shift_nxt = {shift_r[6:0], sdat_s};
            bitcnt_nxt = bitcnt_r + 3'h1;
            if (bitcnt_r == 3'h7) begin
                batt_nxt = {shift_r[6:0], sdat_s};
            end
        end
        lb1_nxt = wr_lb1 ? 8'(merge({24'h0, lb1_r}, wd_r, ws_r)) : lb1_r;
        lb1f_nxt = batt_r <= lb1_r;
    end

    // warning timer, causes and power state machine
    always_comb begin
        logic [NCAUSE-1:0] set;
        logic btn_ok;
        set = '0;
        btn_ok = btn_e & ~lb2_s;
        ctrl_nxt = wr_ctrl ? ctrl_new : ctrl_r;
        warn_nxt = warn_r;
        state_nxt = state_r;
        // a write loads and starts the countdown
        if (wr_warn) begin
            warn_nxt = WARN_W'(merge(32'(warn_r), wd_r, ws_r));
        end else if (warn_r != '0) begin
            warn_nxt = warn_r - WARN_W'(1);
            if (warn_r == WARN_W'(1) && ctrl_r[CTRL_SW_REQ]) begin
                set[CS_SWT] = 1'b1;
            end
        end
        set[CS_BTN] = btn_ok;
        set[CS_LB1] = lb1f_nxt & ~lb1f_r;
        set[CS_LB2] = rise[6];
        case (state_r)
            ST_ON: begin
                if (tmr_s) begin
                    set[CS_IDLE] = ~cause_r[CS_IDLE];
                end
                if (ctrl_r[CTRL_STBY_EN]) begin
                    state_nxt = ST_STBY;
                end
                if (ctrl_r[CTRL_SUSP_REQ]) begin
                    state_nxt = ST_SUSP;
                end
            end
            ST_STBY: begin
                // activity wakes the subsystem
                set[CS_ACT] = act_s & ~cause_r[CS_ACT];
                set[CS_HDD] = hdd_e;
                if (hdd_e || !ctrl_r[CTRL_STBY_EN]) begin
                    state_nxt = ST_ON;
                end else if (ctrl_r[CTRL_SUSP_REQ]) begin
                    state_nxt = ST_SUSP;
                end
            end
            ST_SUSP: begin
                // wake detection keeps running here
                if (btn_ok || wake_e) begin
                    set[CS_WAKE] = 1'b1;
                    state_nxt = ST_WAKE;
                end
            end
            ST_WAKE: begin
                // hold until firmware acknowledges resume
                if (ctrl_r[CTRL_RESUME]) begin
                    state_nxt = ST_ON;
                end
            end
            default: state_nxt = ST_ON;
        endcase
        // leaving suspend drops the suspend request bit
        if (state_r == ST_SUSP && state_nxt == ST_WAKE) begin
            ctrl_nxt[CTRL_SUSP_REQ] = 1'b0;
        end
        // returning from standby to on disarms it, else it would re-enter next cycle
        if (state_r == ST_STBY && state_nxt == ST_ON) begin
            ctrl_nxt[CTRL_STBY_EN] = 1'b0;
        end
        if (state_r == ST_WAKE && state_nxt == ST_ON) begin
            ctrl_nxt[CTRL_RESUME] = 1'b0;
            ctrl_nxt[CTRL_SW_REQ] = 1'b0;
        end
        ctrl_nxt[CTRL_SMI_DONE] = 1'b0;
        // latched until cleared, set wins over clear
        cause_nxt = (cause_r & ~(wr_clr ? wd_r[NCAUSE-1:0]
                     : {NCAUSE{1'b0}})) | set;
        smi_nxt = |cause_nxt;
        // halt: idle in standby, always in suspend
        halt_nxt = (state_nxt == ST_SUSP) |
            (state_nxt == ST_STBY && ctrl_nxt[CTRL_HALT_REQ] && !act_s
             && cause_nxt == '0);
        susp_nxt.clkgen_lowpwr = state_nxt == ST_SUSP;
        susp_nxt.mcu_deep_sleep = state_nxt == ST_SUSP;
        susp_nxt.refresh_slow = state_nxt == ST_SUSP;
        susp_nxt.io_wake_keep = 1'b1;
        // private memory open only while a cause is being serviced
        pmem_nxt = pmem_r;
        if (cause_r != '0 && !pmem_r) begin
            pmem_nxt = 1'b1;
        end else if (wr_ctrl && ctrl_new[CTRL_SMI_DONE]) begin
            pmem_nxt = 1'b0;
        end
        // slow refresh tick while suspended
        refcnt_nxt = refcnt_r;
        tick_nxt = 1'b0;
        if (susp_r.refresh_slow) begin
            if (refcnt_r == 16'(REFRESH_DIV - 1)) begin
                refcnt_nxt = '0;
                tick_nxt = 1'b1;
            end else begin
                refcnt_nxt = refcnt_r + 16'h1;
            end
        end else begin
            refcnt_nxt = '0;
        end
    end

    // registers only
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            ctrl_r <= RESET_WORD;
            cause_r <= '0;
            warn_r <= '0;
            batt_r <= 8'hff;
            lb1_r <= LB1_RESET;
            shift_r <= '0;
            bitcnt_r <= '0;
            state_r <= ST_ON;
            halt_r <= 1'b0;
            pmem_r <= 1'b0;
            refcnt_r <= '0;
            tick_r <= 1'b0;
            susp_r <= '0;
            lb1f_r <= 1'b0;
            smi_r <= 1'b0;
            awrdy_r <= 1'b1;
            wrdy_r <= 1'b1;
            awr_r <= 1'b0;
            awa_r <= '0;
            wr_r <= 1'b0;
            wd_r <= '0;
            ws_r <= '0;
            bv_r <= 1'b0;
            bresp_r <= RESP_OKAY;
            arr_r <= 1'b0;
            rv_r <= 1'b0;
            rd_r <= '0;
            rresp_r <= RESP_OKAY;
        end else begin
            ctrl_r <= ctrl_nxt;
            cause_r <= cause_nxt;
            warn_r <= warn_nxt;
            batt_r <= batt_nxt;
            lb1_r <= lb1_nxt;
            shift_r <= shift_nxt;
            bitcnt_r <= bitcnt_nxt;
            state_r <= state_nxt;
            halt_r <= halt_nxt;
            pmem_r <= pmem_nxt;
            refcnt_r <= refcnt_nxt;
            tick_r <= tick_nxt;
            susp_r <= susp_nxt;
            lb1f_r <= lb1f_nxt;
            smi_r <= smi_nxt;
            awrdy_r <= awrdy_nxt;
            wrdy_r <= wrdy_nxt;
            awr_r <= awr_nxt;
            awa_r <= awa_nxt;
            wr_r <= wr_nxt;
            wd_r <= wd_nxt;
            ws_r <= ws_nxt;
            bv_r <= bv_nxt;
            bresp_r <= bresp_nxt;
            arr_r <= arr_nxt;
            rv_r <= rv_nxt;
            rd_r <= rd_nxt;
            rresp_r <= rresp_nxt;
        end
    end

    // outputs straight from flops
    assign S_AXI_AWREADY = awrdy_r;
    assign S_AXI_WREADY = wrdy_r;
    assign S_AXI_BVALID = bv_r;
    assign S_AXI_BRESP = bresp_r;
    assign S_AXI_ARREADY = arr_r;
    assign S_AXI_RVALID = rv_r;
    assign S_AXI_RDATA = rd_r;
    assign S_AXI_RRESP = rresp_r;
    assign CPU_CLOCK_HALT = halt_r;
    assign SYSTEM_MGMT_INTERRUPT = smi_r;
    assign MGMT_PRIVATE_MEMORY_EN = pmem_r;
    assign REFRESH_TICK = tick_r;
    assign CLKGEN_LOWPWR = susp_r.clkgen_lowpwr;
    assign MCU_DEEP_SLEEP = susp_r.mcu_deep_sleep;
    assign IO_WAKE_ACTIVE = susp_r.io_wake_keep;
    assign LOW_BATT1_FLAG = lb1f_r;

    // assertions
    AST_SUSP_HALT: assert property (
        @(posedge SYS_CLK) disable iff (RST)
        state_r == ST_SUSP |-> halt_r && susp_r.clkgen_lowpwr)
        else $error("halt or clock generator not low in suspend");
    AST_SLEEP: assert property (
        @(posedge SYS_CLK) disable iff (RST)
        state_r == ST_SUSP |-> susp_r.mcu_deep_sleep)
        else $error("controller awake in suspend");
    AST_HDD: assert property (
        @(posedge SYS_CLK) disable iff (RST)
        state_r == ST_STBY && hdd_e |=> state_r == ST_ON)
        else $error("drive access did not end standby");
    AST_LB2: assert property (
        @(posedge SYS_CLK) disable iff (RST)
        state_r == ST_SUSP && lb2_s && !wake_e |=> state_r == ST_SUSP)
        else $error("button left suspend under low battery two");
    AST_LATCH: assert property (
        @(posedge SYS_CLK) disable iff (RST)
        cause_r[CS_BTN] && !wr_clr |=> cause_r[CS_BTN])
        else $error("cause dropped without clear");
    AST_BTN: assert property (
        @(posedge SYS_CLK) disable iff (RST)
        btn_e && !lb2_s |=> cause_r[CS_BTN] ##1 SYSTEM_MGMT_INTERRUPT)
        else $error("button press raised no interrupt");
    AST_WARN: assert property (
        @(posedge SYS_CLK) disable iff (RST)
        warn_r == WARN_W'(1) && !wr_warn && ctrl_r[CTRL_SW_REQ]
        |=> cause_r[CS_SWT])
        else $error("warning expiry not shown");
    AST_LOAD: assert property (
        @(posedge SYS_CLK) disable iff (RST)
        warn_r > WARN_W'(1) && !wr_warn |=> warn_r == $past(warn_r) - 1)
        else $error("warning timer not counting");
    AST_PMEM: assert property (
        @(posedge SYS_CLK) disable iff (RST)
        $rose(pmem_r) |-> $past(cause_r) != '0)
        else $error("private memory opened without service");
    AST_LB1: assert property (
        @(posedge SYS_CLK) disable iff (RST)
        ##1 lb1f_r == ($past(batt_r) <= $past(lb1_r)))
        else $error("low battery flag wrong");
endmodule
`default_nettype wire

// File: dv/sspc_batt_model.sv
// battery pack controller model: sends the status byte serially
`timescale 1ns/1ps
`default_nettype none
module sspc_batt_model (
    input wire logic clk,
    output logic sclk,
    output logic sdata
);
    // link clock rests low outside frames
    initial begin
        sclk = 1'b0;
        sdata = 1'b0;
    end
    // msb first; data settles four clocks (a third of a bit) before the rising edge
    task automatic send(input logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            repeat (4) @(posedge clk);
            sdata <= b[i];
            repeat (4) @(posedge clk);
            sclk <= 1'b1;
            repeat (4) @(posedge clk);
            sclk <= 1'b0;
        end
        // released line shows the inverse so a stale bit never helps
        repeat (4) @(posedge clk);
        sdata <= ~b[0];
    endtask
endmodule
`default_nettype wire

// File: dv/standby_suspend_power_control_bench.sv
// self-checking bench for the standby and suspend power control
`timescale 1ns/1ps
`default_nettype none
module standby_suspend_power_control_bench;
    import sspc_pkg::*;
    // clock, reset and bus master side
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    // watched events and levels
    logic act = 1'b0, hdd = 1'b0, idle = 1'b0, btn = 1'b0;
    logic ring = 1'b0, alarm = 1'b0, lb2 = 1'b0;
    logic sclk, sdata;
    // power control outputs
    logic halt, system_mgmt_interrupt, pmem, rtick, clkgen, mcu, iowake, lb1f;
    // bookkeeping
    int n_mismatch = 0;
    int n_compared = 0;
    int cyc = 0;
    int t0;
    logic [31:0] rd_v;
    logic [1:0] resp_v;
    logic [7:0] sp, bb;

    // 125 MHz system clock
    always #4 clk = ~clk;

    sspc_top #(.WARN_W(32)) DUT (
        .SYS_CLK(clk), .RST(rst),
        .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
        .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
        .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
        .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
        .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
        .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
        .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
        .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
        .S_AXI_RREADY(rready), .PERIPH_ACT(act), .HDD_ACCESS(hdd),
        .TIMERS_EXPIRED(idle), .SUSP_BUTTON(btn), .MODEM_RING(ring),
        .RTC_ALARM(alarm), .LOW_BATT2(lb2), .BATT_SCLK(sclk),
        .BATT_SDATA(sdata), .CPU_CLOCK_HALT(halt),
        .SYSTEM_MGMT_INTERRUPT(system_mgmt_interrupt), .MGMT_PRIVATE_MEMORY_EN(pmem),
        .REFRESH_TICK(rtick), .CLKGEN_LOWPWR(clkgen),
        .MCU_DEEP_SLEEP(mcu), .IO_WAKE_ACTIVE(iowake),
        .LOW_BATT1_FLAG(lb1f)
    );

    // far-side battery controller
    sspc_batt_model u_batt (.clk(clk), .sclk(sclk), .sdata(sdata));

    // compare and count; unknowns never match
    task automatic chk(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // verdict and the only end of the run
    task automatic end_sim;
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // axi4-lite write: address and data offered together
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s);
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk);
            if (awvalid && awready === 1'b1) awvalid <= 1'b0;
            if (wvalid && wready === 1'b1) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        bready <= 1'b0;
        resp_v = bresp;
    endtask

    // axi4-lite read; data taken at the rvalid edge
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk);
            if (arvalid && arready === 1'b1) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        rready <= 1'b0;
        rd_v = rdata;
        resp_v = rresp;
    endtask

    // read a register and compare the masked bits
    task automatic rchk(input string nm, input logic [7:0] a,
                        input logic [31:0] m, input logic [31:0] e);
        rd(a);
        chk(nm, rd_v & m, e);
    endtask

    // one event pulse, long enough to pass the input synchroniser
    task automatic ev(input int k);
        @(posedge clk);
        case (k)
            0: btn <= 1'b1;
            1: ring <= 1'b1;
            2: alarm <= 1'b1;
            3: act <= 1'b1;
            default: hdd <= 1'b1;
        endcase
        repeat (4) @(posedge clk);
        {btn, ring, alarm, act, hdd} <= 5'b0;
        repeat (8) @(posedge clk);
    endtask

    // flag expectation at or below the set point
    function automatic logic [31:0] lb1_exp(logic [7:0] b, logic [7:0] p);
        return (b <= p) ? 32'h1 : 32'h0;
    endfunction

    // refresh interval in system clocks at 32 kHz
    function automatic logic [31:0] refr_period();
        return 32'(125_000_000 / 32_000);
    endfunction

    // watchdog: a hang counts as a mismatch
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            n_mismatch++;
            end_sim();
        end
    end

    initial begin
        void'($urandom(88855));
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        // reset values and an unmapped place
        rchk("lb1_rst", ADDR_LB1, 32'hff, {24'h0, LB1_RESET});
        rchk("batt_rst", ADDR_BATT, 32'hff, 32'hff);
        rchk("stat_rst", ADDR_STAT, 32'hff, 32'h0);
        chk("pmem_rst", 32'(pmem), 32'h0);
        chk("iowake", 32'(iowake), 32'h1);
        rd(8'h1c);
        chk("unmapped_rresp", 32'(resp_v), 32'(RESP_SLVERR));
        chk("unmapped_rdata", rd_v, 32'h0);
        wr(8'h1c, 32'hffff_ffff, 4'hf);
        chk("unmapped_bresp", 32'(resp_v), 32'(RESP_SLVERR));
        // set point, a masked lane, then bytes at it, one above it, one random and 0xff
        sp = 8'($urandom_range(1, 254));
        wr(ADDR_LB1, {24'h0, sp}, 4'hf);
        wr(ADDR_LB1, 32'h0, 4'he);
        rchk("lb1_strb", ADDR_LB1, 32'hff, {24'h0, sp});
        for (int i = 0; i < 4; i++) begin
            bb = (i == 0) ? sp : (i == 1) ? sp + 8'h1 : 8'($urandom);
            if (i == 3) bb = 8'hff;
            u_batt.send(bb);
            repeat (8) @(posedge clk);
            rchk("batt_byte", ADDR_BATT, 32'hff, {24'h0, bb});
            chk("lb1_flag", 32'(lb1f), lb1_exp(bb, sp));
        end
        wr(ADDR_CLR, 32'hff, 4'hf);
        // the low battery cause opened the window; close it first
        wr(ADDR_CTRL, 32'h1 << CTRL_SMI_DONE, 4'hf);
        chk("pmem_shut", 32'(pmem), 32'h0);
        // button cause, a second cause, private memory window
        ev(0);
        rchk("btn_cause", ADDR_STAT, 32'h8, 32'h1 << CS_BTN);
        chk("smi_btn", 32'(system_mgmt_interrupt), 32'h1);
        chk("pmem_on", 32'(pmem), 32'h1);
        idle <= 1'b1;
        repeat (8) @(posedge clk);
        rchk("two_causes", ADDR_STAT, 32'hc, 32'hc);
        idle <= 1'b0;
        wr(ADDR_CLR, 32'hff, 4'hf);
        rchk("stat_clr", ADDR_STAT, 32'hff, 32'h0);
        wr(ADDR_CTRL, 32'h1 << CTRL_SMI_DONE, 4'hf);
        repeat (4) @(posedge clk);
        chk("pmem_off", 32'(pmem), 32'h0);
        chk("smi_off", 32'(system_mgmt_interrupt), 32'h0);
        // software request through the warning timer
        t0 = $urandom_range(32, 63);
        wr(ADDR_WARN, 32'(t0), 4'hf);
        wr(ADDR_CTRL, 32'h1 << CTRL_SW_REQ, 4'hf);
        rchk("warn_early", ADDR_STAT, 32'h10, 32'h0);
        repeat (80) @(posedge clk);
        rchk("warn_done", ADDR_STAT, 32'h10, 32'h10);
        chk("smi_warn", 32'(system_mgmt_interrupt), 32'h1);
        wr(ADDR_CTRL, 32'h0, 4'hf);
        wr(ADDR_CLR, 32'hff, 4'hf);
        // standby halt released by activity, then by drive access
        for (int k = 3; k <= 4; k++) begin
            wr(ADDR_CTRL, 32'h21, 4'hf);
            repeat (4) @(posedge clk);
            chk("stby_halt", 32'(halt), 32'h1);
            ev(k);
            chk("stby_release", 32'(halt), 32'h0);
            rchk("stby_cause", ADDR_STAT, 32'(k - 2), 32'(k - 2));
            if (k == 4) rchk("hdd_exit", ADDR_STATE, 32'h3, 32'(ST_ON));
            wr(ADDR_CTRL, 32'h0, 4'hf);
            wr(ADDR_CLR, 32'hff, 4'hf);
        end
        // suspend, slowed refresh, and each wake source in turn
        for (int k = 0; k < 4; k++) begin
            lb2 <= (k == 0);
            repeat (8) @(posedge clk);
            if (k != 1) begin
                // firmware lets the drives sit idle before asking
                repeat (64) @(posedge clk);
                wr(ADDR_CTRL, 32'h1 << CTRL_SUSP_REQ, 4'hf);
                repeat (4) @(posedge clk);
            end
            rchk("susp_state", ADDR_STATE, 32'h3, 32'(ST_SUSP));
            chk("susp_clkgen", 32'(clkgen), 32'h1);
            chk("susp_halt", 32'(halt), 32'h1);
            chk("susp_mcu", 32'(mcu), 32'h1);
            chk("susp_iowake", 32'(iowake), 32'h1);
            if (k == 2) begin
                do @(posedge clk); while (rtick !== 1'b1);
                t0 = 0;
                do begin
                    @(posedge clk);
                    t0++;
                end while (rtick !== 1'b1);
                chk("refresh_period", 32'(t0), refr_period());
            end
            ev((k < 2) ? 0 : k - 1);
            chk("wake_halt", 32'(halt), (k == 0) ? 1 : 0);
            rchk("wake_state", ADDR_STATE, 32'h3,
                 (k == 0) ? 32'(ST_SUSP) : 32'(ST_WAKE));
            if (k != 0) begin
                // status cleared before the devices are brought back
                wr(ADDR_CLR, 32'hff, 4'hf);
                wr(ADDR_CTRL, 32'h1 << CTRL_RESUME, 4'hf);
                repeat (4) @(posedge clk);
                chk("resume_clkgen", 32'(clkgen), 32'h0);
                rchk("resume_state", ADDR_STATE, 32'h3, 32'(ST_ON));
            end
        end
        end_sim();
    end
endmodule
`default_nettype wire
